// ---- core/irq_vector_info_readout.sv ----
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "irq_vec_defs.svh"

// Functional notes
// - One writable vector store per source, 64
// - Vector readout shows the winning standard (non-fast) source's vector
// - Vector readout is read-only 32-bit word
// - Info reports number bits 5:0, level 10:8
// - Number and level fields ignore writes
// - Same level: lowest source number first
// - Rotation masks acknowledged source if another live source shares its level, until level drained
// - Writing one to bit 24 disables rotation
// - Bit 24 reads one when nothing asserted
// - Rotation governs standard and fast paths
module irq_vector_info_readout #(
    parameter int NUM_SRC = 64,
    parameter int LVL_W   = 3
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [NUM_SRC-1:0]       src_pending,
    input  wire logic [NUM_SRC-1:0]       src_is_fast,
    input  wire logic [NUM_SRC*LVL_W-1:0] src_level,
    output logic                          irq_req,
    output logic                          fiq_req,
    output logic      [NUM_SRC-1:0]       ack_pulse,
    output logic                          event_irq
);

    if (NUM_SRC != 64 || LVL_W != 3) begin : g_check
        $error("Only 64 sources with 3-bit levels are supported");
    end

    typedef struct packed {
        logic [NUM_SRC-1:0][31:0] vec;
        logic [NUM_SRC-1:0]       rot;
        logic                     rot_off;
        irq_vec_pkg::pick_s       irq;
        irq_vec_pkg::pick_s       fiq;
        logic [`EVT_W-1:0]        evt_sts;
        logic [`EVT_W-1:0]        evt_en;
        logic                     evt_line;
        logic [NUM_SRC-1:0]       ack;
        logic                     pready;
        logic                     pslverr;
        logic [31:0]              prdata;
    } state_s;

    state_s state_r;
    state_s state_nxt;

    function automatic irq_vec_pkg::level_t level_of(input logic [NUM_SRC*LVL_W-1:0] lv,
                                                     input int idx);
        level_of = lv[idx*LVL_W +: LVL_W];
    endfunction : level_of

    // Highest level wins, lowest number within a level
    function automatic irq_vec_pkg::pick_s pick(input logic [NUM_SRC-1:0]       cand,
                                                input logic [NUM_SRC*LVL_W-1:0] lv);
        irq_vec_pkg::pick_s p;
        p = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (cand[i] && (!p.found || level_of(lv, i) >= p.lvl)) begin
                p.found = 1'b1;
                p.num   = irq_vec_pkg::srcnum_t'(i);
                p.lvl   = level_of(lv, i);
            end
        end
        return p;
    endfunction : pick

    function automatic logic is_vec_addr(input logic [11:0] a);
        is_vec_addr = (a >= `OFS_VEC_BASE) && (a <= `OFS_VEC_LAST) && (a[1:0] == 2'h0);
    endfunction : is_vec_addr

    function automatic logic is_mapped(input logic [11:0] a);
        if (is_vec_addr(a)) begin
            is_mapped = 1'b1;
        end else begin
            case (a)
                `OFS_ACKNOWLEDGE_LOW_WORD:      is_mapped = 1'b1;
                `OFS_ACKNOWLEDGE_HIGH_WORD:      is_mapped = 1'b1;
                `OFS_VEC_READOUT: is_mapped = 1'b1;
                `OFS_SRC_INFO:    is_mapped = 1'b1;
                `OFS_EVT_STATUS:  is_mapped = 1'b1;
                `OFS_EVT_CLEAR:   is_mapped = 1'b1;
                `OFS_EVT_ENABLE:  is_mapped = 1'b1;
                default:          is_mapped = 1'b0;
            endcase
        end
    endfunction : is_mapped

    // Write strobe for one register offset
    function automatic logic wr_hit(input logic        acc,
                                    input logic [11:0] a,
                                    input logic [11:0] ofs);
        wr_hit = acc && (a == ofs);
    endfunction : wr_hit

    // Vector store entry hit by a write
    function automatic logic vec_hit(input logic        acc,
                                     input logic [11:0] a,
                                     input int          idx);
        vec_hit = acc && is_vec_addr(a) && (a[7:2] == 6'(idx));
    endfunction : vec_hit

    // Acknowledge bits from a write to either word
    function automatic logic [NUM_SRC-1:0] ack_decode(input logic        acc,
                                                      input logic [11:0] a,
                                                      input logic [31:0] d);
        ack_decode = '0;
        if (wr_hit(acc, a, `OFS_ACKNOWLEDGE_LOW_WORD)) begin
            ack_decode[31:0] = d;
        end
        if (wr_hit(acc, a, `OFS_ACKNOWLEDGE_HIGH_WORD)) begin
            ack_decode[63:32] = d;
        end
    endfunction : ack_decode

    // Live candidates of one level
    function automatic logic [NUM_SRC-1:0] lvl_members(input logic [NUM_SRC-1:0]       cand,
                                                       input logic [NUM_SRC*LVL_W-1:0] lv,
                                                       input int                       l);
        lvl_members = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            lvl_members[i] = cand[i] && (level_of(lv, i) == LVL_W'(l));
        end
    endfunction : lvl_members

    // More than one bit set
    function automatic logic more_than_one(input logic [NUM_SRC-1:0] v);
        more_than_one = |(v & (v - NUM_SRC'(1)));
    endfunction : more_than_one

    // Next rotation mask bit of one source
    function automatic logic rot_next(input logic cur,
                                      input logic off,
                                      input logic acked,
                                      input logic is_live,
                                      input logic multi,
                                      input logic lvl_has);
        if (off) begin
            rot_next = 1'b0;
        end else if (acked && is_live && multi) begin
            rot_next = 1'b1;
        end else if (!lvl_has) begin
            rot_next = 1'b0;
        end else begin
            rot_next = cur;
        end
    endfunction : rot_next

    // Events raised in this cycle
    function automatic logic [`EVT_W-1:0] evt_events(input irq_vec_pkg::pick_s now_irq,
                                                     input irq_vec_pkg::pick_s was_irq,
                                                     input irq_vec_pkg::pick_s now_fiq,
                                                     input irq_vec_pkg::pick_s was_fiq,
                                                     input logic               any_ack);
        evt_events               = '0;
        evt_events[`EVT_IRQ_NEW] = now_irq.found && !was_irq.found;
        evt_events[`EVT_FIQ_NEW] = now_fiq.found && !was_fiq.found;
        evt_events[`EVT_ACK]     = any_ack;
    endfunction : evt_events

    // Sticky event status: set wins over clear
    function automatic logic [`EVT_W-1:0] evt_next(input logic [`EVT_W-1:0] cur,
                                                   input logic [`EVT_W-1:0] set,
                                                   input logic              clr_wr,
                                                   input logic [`EVT_W-1:0] clr);
        evt_next = cur;
        if (clr_wr) begin
            evt_next = cur & ~clr;
        end
        evt_next = evt_next | set;
    endfunction : evt_next

    // Info word: number, level and rotation bit
    function automatic logic [31:0] info_value(input irq_vec_pkg::pick_s p,
                                               input logic               off);
        info_value = '0;
        if (p.found) begin
            info_value[`INFO_NUM_MSB:`INFO_NUM_LSB] = p.num;
            info_value[`INFO_LVL_MSB:`INFO_LVL_LSB] = p.lvl;
            info_value[`INFO_ROT_BIT]               = off;
        end else begin
            info_value[`INFO_NUM_MSB:`INFO_NUM_LSB] = 6'h3f;
            info_value[`INFO_LVL_MSB:`INFO_LVL_LSB] = 3'h7;
            info_value[`INFO_ROT_BIT]               = 1'b1;
        end
    endfunction : info_value

    // Read data of one register offset
    function automatic logic [31:0] read_mux(input logic [11:0]              a,
                                             input logic [NUM_SRC-1:0][31:0] vec,
                                             input irq_vec_pkg::pick_s       p,
                                             input logic [31:0]              info,
                                             input logic [`EVT_W-1:0]        sts,
                                             input logic [`EVT_W-1:0]        en);
        read_mux = '0;
        if (is_vec_addr(a)) begin
            read_mux = vec[a[7:2]];
        end else begin
            case (a)
                `OFS_VEC_READOUT: begin
                    if (p.found) begin
                        read_mux = vec[p.num];
                    end else begin
                        read_mux = `VEC_IDLE;
                    end
                end
                `OFS_SRC_INFO: begin
                    read_mux = info;
                end
                `OFS_EVT_STATUS: begin
                    read_mux = 32'(sts);
                end
                `OFS_EVT_ENABLE: begin
                    read_mux = 32'(en);
                end
                default: begin
                    read_mux = '0;
                end
            endcase
        end
    endfunction : read_mux

    // Read data handed out in the access cycle
    function automatic logic [31:0] answer_data(input logic        wr,
                                                input logic [11:0] a,
                                                input logic [31:0] word);
        if (!wr && is_mapped(a)) begin
            answer_data = word;
        end else begin
            answer_data = '0;
        end
    endfunction : answer_data

    logic               setup;
    logic               wr_acc;
    logic [NUM_SRC-1:0] ack_wr;
    logic [NUM_SRC-1:0] live;
    logic [7:0]         lvl_open;
    logic [7:0]         lvl_multi;
    logic [NUM_SRC-1:0] lvl_vec [8];
    logic [31:0]        rd_word;
    logic [31:0]        info_word;
    logic [`EVT_W-1:0]  evt_set;
    irq_vec_pkg::pick_s irq_pick;
    irq_vec_pkg::pick_s fiq_pick;

    always_comb begin
        state_nxt = state_r;
        setup     = psel && !penable;
        wr_acc    = psel && penable && pwrite && state_r.pready && !state_r.pslverr;

        ack_wr = ack_decode(wr_acc, paddr, pwdata);

        // Candidates after rotation masking, shared by both paths
        live = src_pending & ~(state_r.rot & {NUM_SRC{!state_r.rot_off}});
        for (int l = 0; l < 8; l++) begin
            lvl_vec[l]   = lvl_members(live, src_level, l);
            lvl_open[l]  = |lvl_vec[l];
            lvl_multi[l] = more_than_one(lvl_vec[l]);
        end

        irq_pick = pick(live & ~src_is_fast, src_level);
        fiq_pick = pick(live & src_is_fast, src_level);

        // Rotation mask upkeep
        for (int i = 0; i < NUM_SRC; i++) begin
            state_nxt.rot[i] = rot_next(state_r.rot[i],
                                        state_r.rot_off,
                                        ack_wr[i],
                                        live[i],
                                        lvl_multi[level_of(src_level, i)],
                                        lvl_open[level_of(src_level, i)]);
        end

        state_nxt.irq = irq_pick;
        state_nxt.fiq = fiq_pick;
        state_nxt.ack = ack_wr;

        // Event flags: set wins over clear
        evt_set = evt_events(irq_pick, state_r.irq, fiq_pick, state_r.fiq, |ack_wr);
        state_nxt.evt_sts = evt_next(state_r.evt_sts,
                                     evt_set,
                                     wr_hit(wr_acc, paddr, `OFS_EVT_CLEAR),
                                     pwdata[`EVT_W-1:0]);
        if (wr_acc && paddr == `OFS_EVT_ENABLE) begin
            state_nxt.evt_en = pwdata[`EVT_W-1:0];
        end
        state_nxt.evt_line = |(state_nxt.evt_sts & state_nxt.evt_en);

        // Register writes
        if (wr_acc && paddr == `OFS_SRC_INFO) begin
            state_nxt.rot_off = pwdata[`INFO_ROT_BIT];
        end
        for (int i = 0; i < NUM_SRC; i++) begin
            if (vec_hit(wr_acc, paddr, i)) begin
                state_nxt.vec[i] = pwdata;
            end
        end

        // Read data
        info_word = info_value(state_r.irq, state_r.rot_off);
        rd_word   = read_mux(paddr, state_r.vec, state_r.irq, info_word,
                             state_r.evt_sts, state_r.evt_en);

        // APB: answer in first access cycle
        state_nxt.pready  = setup;
        state_nxt.pslverr = setup && !is_mapped(paddr);
        if (setup) begin
            state_nxt.prdata = answer_data(pwrite, paddr, rd_word);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r          <= '0;
            state_r.rot_off  <= `ROT_OFF_RST;
            state_r.evt_en   <= `EVT_EN_RST;
            for (int i = 0; i < NUM_SRC; i++) begin
                state_r.vec[i] <= `VEC_STORE_RST;
            end
        end else begin
            state_r <= state_nxt;
        end
    end

    assign prdata    = state_r.prdata;
    assign pready    = state_r.pready;
    assign pslverr   = state_r.pslverr;
    assign irq_req   = state_r.irq.found;
    assign fiq_req   = state_r.fiq.found;
    assign ack_pulse = state_r.ack;
    assign event_irq = state_r.evt_line;

endmodule : irq_vector_info_readout

// ---- core/irq_vec_defs.svh ----
`ifndef IRQ_VEC_DEFS_SVH
`define IRQ_VEC_DEFS_SVH

// Register byte offsets
`define OFS_ACKNOWLEDGE_LOW_WORD      12'h060
`define OFS_ACKNOWLEDGE_HIGH_WORD      12'h064
`define OFS_VEC_READOUT 12'h068
`define OFS_SRC_INFO    12'h06c
`define OFS_EVT_STATUS  12'h0a0
`define OFS_EVT_CLEAR   12'h0a4
`define OFS_EVT_ENABLE  12'h0a8
`define OFS_VEC_BASE    12'h100
`define OFS_VEC_LAST    12'h1fc

// Info register field positions
`define INFO_NUM_LSB    0
`define INFO_NUM_MSB    5
`define INFO_LVL_LSB    8
`define INFO_LVL_MSB    10
`define INFO_ROT_BIT    24

// Reset and idle values
`define VEC_IDLE        32'h0fffffff
`define VEC_STORE_RST   32'h00000000
`define EVT_EN_RST      3'h0
`define ROT_OFF_RST     1'h0

// Event status bit positions
`define EVT_IRQ_NEW     0
`define EVT_FIQ_NEW     1
`define EVT_ACK         2
`define EVT_W           3

`endif

// ---- core/irq_vec_pkg.sv ----
package irq_vec_pkg;
    typedef logic [31:0] word_t;
    typedef logic [2:0]  level_t;
    typedef logic [5:0]  srcnum_t;
    typedef struct packed {
        logic    found;
        srcnum_t num;
        level_t  lvl;
    } pick_s;
endpackage : irq_vec_pkg

// ---- testbench/irq_readout_monitor.sv ----
`timescale 1ns/1ps
module irq_readout_monitor #(
    parameter int NUM_SRC = 64
) (
    input wire logic               ref_clk,
    input wire logic               rst_n,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [11:0]        paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic [NUM_SRC-1:0] src_pending,
    input wire logic               irq_req,
    input wire logic               fiq_req,
    input wire logic [NUM_SRC-1:0] ack_pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire acc  = psel && penable && pready;
    wire rd_a = acc && !pwrite;
    logic [2:0] idle_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            idle_q <= '0;
        end else begin
            idle_q <= {idle_q[1:0], src_pending == '0};
        end
    end
    wire quiet = idle_q[2] && idle_q[1];
    chk_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");
    chk_ack_low: assert property (acc && pwrite && paddr == 12'h060
        |=> ack_pulse[31:0] == $past(pwdata))
        else $error("low acknowledge pulse wrong");
    chk_ack_high: assert property (acc && pwrite && paddr == 12'h064
        |=> ack_pulse[NUM_SRC-1:32] == $past(pwdata))
        else $error("high acknowledge pulse wrong");
    chk_ack_quiet: assert property (!(acc && pwrite && paddr[11:3] == 9'h00c)
        |=> ack_pulse == '0)
        else $error("acknowledge pulse without write");
    chk_vec_idle: assert property (rd_a && paddr == 12'h068 && quiet
        |-> prdata == 32'h0fffffff)
        else $error("idle vector readout wrong");
    chk_info_idle: assert property (rd_a && paddr == 12'h06c && quiet
        |-> prdata == 32'h0100073f)
        else $error("idle info readout wrong");
    chk_info_resv: assert property (rd_a && paddr == 12'h06c
        |-> (prdata & 32'hfefff8c0) == '0)
        else $error("info reserved bits set");
    chk_req_idle: assert property (src_pending == '0 |=> !(irq_req || fiq_req))
        else $error("request without pending source");
endmodule : irq_readout_monitor

bind irq_vector_info_readout irq_readout_monitor #(.NUM_SRC(NUM_SRC)) mon_inst (.ref_clk, .rst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .src_pending, .irq_req, .fiq_req, .ack_pulse);

// ---- testbench/irq_vector_info_readout_tb.sv ----
`timescale 1ns/1ps
module irq_vector_info_readout_tb;
    logic         ref_clk, rst_n, psel, penable, pwrite, err;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rnd, rd;
    logic         pready, pslverr, irq_req, fiq_req, event_irq;
    logic [63:0]  src_pending, src_is_fast, ack_pulse;
    logic [191:0] src_level;
    logic [31:0]  vec [64];
    logic [5:0]   s;
    logic [2:0]   l;
    int           n_fail, comparisons, cyc;

    irq_vector_info_readout irq_vector_info_readout_inst (.ref_clk, .rst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .src_pending, .src_is_fast,
        .src_level, .irq_req, .fiq_req, .ack_pulse, .event_irq);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    task automatic close_out();
        if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rchk

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            close_out();
        end
    end

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {src_pending, src_is_fast, src_level} = '0;
        {n_fail, comparisons, cyc} = '0;
        rnd = 32'h00000035;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rchk("vec_idle", 12'h068, 32'h0fffffff);
        rchk("info_idle", 12'h06c, 32'h0100073f);
        for (int i = 0; i < 64; i++) begin
            rnd = lfsr(rnd);
            vec[i] = rnd;
            apb(1'b1, 12'(256 + 4 * i), rnd);
        end
        rchk("store_last", 12'h1fc, vec[63]);
        apb(1'b1, 12'h0f0, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            s = rnd[5:0];
            l = rnd[10:8];
            src_pending <= 64'h1 << s;
            src_level <= 192'(l) << (3 * s);
            repeat (2) @(posedge ref_clk);
            rchk("vec", 12'h068, vec[s]);
            rchk("info", 12'h06c, {21'h0, l, 2'h0, s});
        end
        apb(1'b1, 12'h068, 32'h0);
        apb(1'b1, 12'h06c, 32'hfeffffff);
        rchk("vec_ro", 12'h068, vec[s]);
        rchk("info_ro", 12'h06c, {21'h0, l, 2'h0, s});
        src_pending <= 64'h40100400;
        src_level <= (192'h3 << 30) | (192'h3 << 60) | (192'h1 << 90);
        repeat (2) @(posedge ref_clk);
        rchk("lowest_first", 12'h06c, 32'h0000030a);
        apb(1'b1, 12'h060, 32'h00000400);
        rchk("rotated", 12'h06c, 32'h00000314);
        apb(1'b1, 12'h06c, 32'h01000000);
        rchk("rot_off", 12'h06c, 32'h0100030a);
        apb(1'b1, 12'h06c, 32'h0);
        src_is_fast <= '1;
        repeat (2) @(posedge ref_clk);
        chk("fiq", 32'h1, {31'h0, fiq_req});
        chk("irq", 32'h0, {31'h0, irq_req});
        src_pending <= '0;
        src_is_fast <= '0;
        apb(1'b1, 12'h0a4, 32'h7);
        apb(1'b1, 12'h0a8, 32'h1);
        chk("evt_clear", 32'h0, {31'h0, event_irq});
        src_pending <= 64'h20;
        repeat (2) @(posedge ref_clk);
        chk("evt_set", 32'h1, {31'h0, event_irq});
        apb(1'b1, 12'h0a8, 32'h0);
        chk("evt_mask", 32'h0, {31'h0, event_irq});
        close_out();
    end
endmodule : irq_vector_info_readout_tb
